// ==== src/btg_top.sv ====
`timescale 1ns/1ps
module btg_top
(
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire btg_pkg::btg_instr_s  instr,
    output logic [btg_pkg::PC_W-1:0]  pc_q,
    output logic                      branched_q
);
    import btg_pkg::*;

    logic [PC_W-1:0] next_seq;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] pc_d;
    logic            branched_d;

    // following instruction start, wraps like the pc itself
    assign next_seq = pc_q + PC_W'(instr.length);

    btg_adder u_adder
    (
        .base                  (next_seq),
        .relative_displacement (instr.relative_displacement),
        .sum                   (rel_target)
    );

    always_comb
    begin
        pc_d       = pc_q;
        branched_d = 1'b0;
        if (instr.valid)
        begin
            case (instr.kind)
                BTG_REL:
                begin
                    pc_d       = rel_target;
                    branched_d = 1'b1;
                end
                BTG_CONDR:
                begin
                    pc_d       = instr.cond_taken ? rel_target : next_seq;
                    branched_d = instr.cond_taken;
                end
                BTG_ABS:
                begin
                    // whole 16-bit word, no region limit
                    pc_d       = instr.absolute_target;
                    branched_d = 1'b1;
                end
                default:
                begin
                    pc_d = next_seq;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pc_q       <= PC_RESET;
            branched_q <= 1'b0;
        end
        else
        begin
            pc_q       <= pc_d;
            branched_q <= branched_d;
        end
    end

    sequence seq_step_s;
        instr.valid && instr.kind == BTG_SEQ;
    endsequence

    sequence rel_taken_s;
        instr.valid && (instr.kind == BTG_REL || (instr.kind == BTG_CONDR && instr.cond_taken));
    endsequence

    seq_advance_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_step_s |=> pc_q == PC_W'($past(pc_q) + $past(instr.length)))
        else $error("pc did not advance by instruction length");

    rel_target_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rel_taken_s |=> pc_q == PC_W'($past(pc_q) + $past(instr.length)
                                + {{8{$past(instr.relative_displacement[7])}}, $past(instr.relative_displacement)}))
        else $error("relative target wrong");

    neg_disp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rel_taken_s ##0 instr.relative_displacement == 8'h80
        |=> pc_q == PC_W'($past(pc_q) + $past(instr.length) - 16'h0080))
        else $error("displacement not sign-extended");

    cond_not_taken_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        instr.valid && instr.kind == BTG_CONDR && !instr.cond_taken
        |=> !branched_q && pc_q == PC_W'($past(pc_q) + $past(instr.length)))
        else $error("untaken conditional branch moved pc wrongly");

    abs_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        instr.valid && instr.kind == BTG_ABS |=> branched_q && pc_q == $past(instr.absolute_target))
        else $error("absolute target not loaded");

    abs_top_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        instr.valid && instr.kind == BTG_ABS && instr.absolute_target == 16'hFFFF |=> pc_q == 16'hFFFF)
        else $error("absolute target restricted");

    wrap_sum_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rel_taken_s ##0 pc_q == 16'hFFFE ##0 instr.length == 3'h2 ##0 instr.relative_displacement == 8'h01
        |=> pc_q == 16'h0001)
        else $error("relative sum did not wrap");

    hold_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !instr.valid |=> $stable(pc_q) && !branched_q)
        else $error("pc moved without instruction");

    sequence cond_taken_s;
        instr.valid && instr.kind == BTG_CONDR && instr.cond_taken;
    endsequence

    sequence abs_step_s;
        instr.valid && instr.kind == BTG_ABS;
    endsequence

    sequence odd_kind_s;
        instr.valid && !(instr.kind inside {BTG_SEQ, BTG_REL, BTG_CONDR, BTG_ABS});
    endsequence

    // most negative reach from the bottom of memory borrows out of bit 15
    sequence borrow_edge_s;
        rel_taken_s ##0 pc_q == 16'h0000 ##0 instr.length == 3'h2 ##0 instr.relative_displacement == 8'h80;
    endsequence

    seq_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_step_s |=> !branched_q)
        else $error("sequential step flagged as branch");

    zero_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_step_s ##0 instr.length == 3'h0 |=> $stable(pc_q))
        else $error("zero-length step moved pc");

    odd_kind_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        odd_kind_s |=> !branched_q && pc_q == PC_W'($past(pc_q) + $past(instr.length)))
        else $error("unknown kind code did not advance plainly");

    rel_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rel_taken_s |=> branched_q)
        else $error("taken relative branch not flagged");

    cond_taken_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cond_taken_s |=> pc_q == PC_W'($past(pc_q) + $past(instr.length)
                                + {{8{$past(instr.relative_displacement[7])}}, $past(instr.relative_displacement)}))
        else $error("taken conditional branch missed relative target");

    pos_disp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rel_taken_s ##0 instr.relative_displacement == 8'h7F
        |=> pc_q == PC_W'($past(pc_q) + $past(instr.length) + 16'h007F))
        else $error("largest forward displacement wrong");

    sign_fill_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rel_taken_s ##0 instr.relative_displacement == 8'hFF
        |=> pc_q == PC_W'($past(pc_q) + $past(instr.length) - 16'h0001))
        else $error("minus one displacement not filled with sign");

    borrow_wrap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        borrow_edge_s |=> pc_q == 16'hFF82)
        else $error("relative sum did not wrap below zero");

    abs_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        abs_step_s ##0 instr.absolute_target == 16'h0000 |=> pc_q == 16'h0000 && branched_q)
        else $error("absolute target zero not reached");

    flag_cause_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        branched_q |-> $past(instr.valid) && ($past(instr.kind) == BTG_REL || $past(instr.kind) == BTG_ABS
                        || ($past(instr.kind) == BTG_CONDR && $past(instr.cond_taken))))
        else $error("branch flag without a taken branch");

    // no disable here: this one watches the reset itself
    reset_clear_a: assert property (@(posedge ref_clk)
        sys_rst |=> pc_q == PC_RESET && !branched_q)
        else $error("reset did not clear pc and flag");

    // helper for the idle-run check only; pc captured on the first idle edge
    // so a slow drift over several stalls is caught, not just a one-cycle jump
    logic [3:0]      idle_run_q;
    logic [3:0]      idle_run_d;
    logic [PC_W-1:0] idle_pc_q;
    logic [PC_W-1:0] idle_pc_d;

    always_comb
    begin
        idle_run_d = 4'h0;
        idle_pc_d  = idle_pc_q;
        if (!instr.valid)
        begin
            // saturate so a long stall cannot roll back to zero
            idle_run_d = (idle_run_q == 4'hF) ? 4'hF : idle_run_q + 4'h1;
            if (idle_run_q == 4'h0)
            begin
                idle_pc_d = pc_q;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            idle_run_q <= 4'h0;
            idle_pc_q  <= PC_RESET;
        end
        else
        begin
            idle_run_q <= idle_run_d;
            idle_pc_q  <= idle_pc_d;
        end
    end

    idle_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        idle_run_q != 4'h0 |-> pc_q == idle_pc_q)
        else $error("pc drifted during an idle run");

endmodule : btg_top

// ==== src/btg_pkg.sv ====
package btg_pkg;

    localparam int          PC_W       = 16;
    localparam int          LEN_W      = 3;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam int          DISP_SIGN  = 7;

    typedef enum logic [3:0]
    {
        BTG_SEQ   = 4'h1,
        BTG_REL   = 4'h2,
        BTG_CONDR = 4'h4,
        BTG_ABS   = 4'h8
    } btg_kind_e;

    typedef struct packed
    {
        logic                valid;
        btg_kind_e           kind;
        logic                cond_taken;
        logic [LEN_W-1:0]    length;
        logic [7:0]          relative_displacement;
        logic [PC_W-1:0]     absolute_target;
    } btg_instr_s;

    function automatic logic [PC_W-1:0] btg_sext8(input logic [7:0] d);
        btg_sext8 = {{(PC_W-8){d[DISP_SIGN]}}, d};
    endfunction : btg_sext8

endpackage : btg_pkg

// ==== src/btg_adder.sv ====
`timescale 1ns/1ps
module btg_adder
(
    input  wire logic [btg_pkg::PC_W-1:0] base,
    input  wire logic [7:0]               relative_displacement,
    output logic      [btg_pkg::PC_W-1:0] sum
);
    import btg_pkg::*;

    // carry out of bit 15 dropped by width
    assign sum = base + btg_sext8(relative_displacement);

endmodule : btg_adder

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    import btg_pkg::*;
    logic             ref_clk;
    logic             sys_rst;
    btg_instr_s       instr;
    logic [PC_W-1:0]  pc_q;
    logic             branched_q;
    logic [PC_W-1:0]  exp_pc;
    int               n_errors;
    int               cmp_count;
    btg_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr(instr), .pc_q(pc_q), .branched_q(branched_q));
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic btg_instr_s mk(input logic [3:0] k, input logic t, input logic [2:0] l,
                                      input logic [7:0] d, input logic [15:0] a);
        mk = '{1'b1, btg_kind_e'(k), t, l, d, a};
    endfunction : mk
    function automatic logic taken(input btg_instr_s i);
        taken = i.valid && (i.kind == BTG_REL || i.kind == BTG_ABS || (i.kind == BTG_CONDR && i.cond_taken));
    endfunction : taken
    // unknown kind codes fall to plain advance
    function automatic logic [15:0] next_pc(input logic [15:0] p, input btg_instr_s i);
        if (!i.valid) next_pc = p;
        else if (i.kind == BTG_ABS) next_pc = i.absolute_target;
        else if (taken(i)) next_pc = p + 16'(i.length) + {{8{i.relative_displacement[7]}}, i.relative_displacement};
        else next_pc = p + 16'(i.length);
    endfunction : next_pc
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic step(input btg_instr_s i);
        logic br;
        instr = i;
        br = taken(i);
        exp_pc = next_pc(exp_pc, i);
        @(negedge ref_clk);
        check(pc_q, exp_pc);
        check({15'h0, branched_q}, {15'h0, br});
    endtask : step
    initial
    begin
        #50000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        void'($urandom(57));
        sys_rst = 1'b1;
        instr = '0;
        exp_pc = 16'h0000;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(pc_q, 16'h0000);
        check({15'h0, branched_q}, 16'h0000);
        step(mk(4'h1, 1'b0, 3'h3, 8'h00, 16'h1234));
        repeat (3) step('0);
        step(mk(4'h2, 1'b0, 3'h2, 8'h80, 16'h0000));
        step(mk(4'h2, 1'b0, 3'h2, 8'h7F, 16'h0000));
        step(mk(4'h4, 1'b0, 3'h2, 8'h10, 16'hFFFF));
        step(mk(4'h4, 1'b1, 3'h2, 8'hF0, 16'hFFFF));
        step(mk(4'h8, 1'b0, 3'h1, 8'h05, 16'hFFFF));
        step(mk(4'h1, 1'b0, 3'h1, 8'h00, 16'h0000));
        step(mk(4'h3, 1'b1, 3'h4, 8'h40, 16'hABCD));
        step(mk(4'h1, 1'b0, 3'h0, 8'h00, 16'h0000));
        // carry out of bit 15, then the bottom of memory
        step(mk(4'h8, 1'b0, 3'h1, 8'h00, 16'hFFFE));
        step(mk(4'h2, 1'b0, 3'h2, 8'h01, 16'h0000));
        step(mk(4'h8, 1'b0, 3'h1, 8'h00, 16'h0000));
        repeat (200) step(mk(4'h1 << $urandom_range(0, 3), 1'($urandom), 3'($urandom), 8'($urandom), 16'($urandom)));
        // reset in mid-run must win over a branch
        sys_rst = 1'b1;
        instr = mk(4'h8, 1'b0, 3'h1, 8'h00, 16'h5555);
        @(negedge ref_clk);
        check(pc_q, 16'h0000);
        check({15'h0, branched_q}, 16'h0000);
        // first request right after release borrows below zero
        sys_rst = 1'b0;
        exp_pc = PC_RESET;
        step(mk(4'h2, 1'b0, 3'h2, 8'h80, 16'h0000));
        step(mk(4'h4, 1'b1, 3'h1, 8'h7F, 16'h0000));
        step(mk(4'h4, 1'b1, 3'h1, 8'hFF, 16'h0000));
        end_sim();
    end
endmodule : tb
